// >>> dsl_pkg.sv
// package: constants and types for the serial load block
package dsl_pkg;
   // ******************************************
   // word and timing constants
   // ******************************************
   localparam int WORD_BITS     = 16;
   localparam int CNT_BITS      = 5;
   localparam logic [CNT_BITS-1:0] CNT_RESET = 5'h00;
   localparam logic [CNT_BITS-1:0] CNT_FULL  = 5'h10;
   localparam logic [WORD_BITS-1:0] WORD_RESET = 16'h0000;
   localparam int CLK_PERIOD_PS = 5000;
   localparam int STROBE_MIN_NS = 100;
   localparam int STROBE_MIN_CYC =
      (STROBE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int SYNC_STAGES   = 3;
   localparam int BUF_DEPTH     = 2;

   // ******************************************
   // types
   // ******************************************
   typedef enum logic [1:0] {
      DSL_IDLE  = 2'b00,
      DSL_SHIFT = 2'b01,
      DSL_HOLD  = 2'b10
   } dsl_link_e;

   typedef struct packed {
      logic [WORD_BITS-1:0] data;
      logic                 chained;
   } dsl_word_s;

   typedef struct packed {
      logic sync_n;
      logic load_n;
      logic chain;
   } dsl_pins_s;
endpackage

// >>> dsl_buf2.sv
// two-entry valid/ready buffer
`timescale 1ns/1ps
`default_nettype none
module dsl_buf2 #(
   parameter int WIDTH = 17
) (
   input  wire logic             clk_in,    // system clock
   input  wire logic             rstn_in,   // async reset, low
   input  wire logic             in_valid_in, // write valid
   output logic                  in_ready_out, // room left
   input  wire logic [WIDTH-1:0] in_data_in,   // write data
   output logic                  out_valid_out, // data held
   input  wire logic             out_ready_in,  // reader takes
   output logic [WIDTH-1:0]      out_data_out   // head data
);
   logic [WIDTH-1:0] mem [2];
   logic             rd_ptr;
   logic             wr_ptr;
   logic [1:0]       count;
   logic             push;
   logic             pop;

   assign in_ready_out  = (count != 2'h2);
   assign out_valid_out = (count != 2'h0);
   assign push = in_valid_in && in_ready_out;
   assign pop  = out_valid_out && out_ready_in;
   assign out_data_out = mem[rd_ptr];

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         mem[0] <= '0;
         mem[1] <= '0;
      end else if (push) begin
         mem[wr_ptr] <= in_data_in;
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rd_ptr <= 1'b0;
         wr_ptr <= 1'b0;
         count  <= 2'h0;
      end else begin
         if (push) wr_ptr <= ~wr_ptr;
         if (pop)  rd_ptr <= ~rd_ptr;
         count <= count + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule
`default_nettype wire

// >>> dsl_serial_load.sv
// serial load front end with output latch and chaining
`timescale 1ns/1ps
`default_nettype none

module dsl_serial_load
   import dsl_pkg::*;
(
   input  wire logic                 clk_in,       // system clock
   input  wire logic                 rstn_in,      // async reset, low
   input  wire logic                 sclk_in,      // link serial clock
   input  wire logic                 sdata_in,     // link serial data
   input  wire logic                 sync_n_in,    // frame sync, low
   input  wire logic                 load_output_strobe_n_in, // load
   input  wire logic                 chain_enable_in, // chaining on
   output logic                      sdata_out,    // chain serial out
   output logic [WORD_BITS-1:0]      dac_word_out, // output latch
   output logic                      update_out,   // latch update pulse
   output logic                      word_valid_out, // word pending
   input  wire logic                 word_ready_in   // consumer ready
);
   // ******************************************
   // link domain: shift register on falling sclk
   // ******************************************
   logic [WORD_BITS-1:0] shreg;
   logic [CNT_BITS-1:0]  bit_cnt;
   logic                 auto_tog;
   logic [WORD_BITS-1:0] auto_word;
   logic                 chain_l1;
   logic                 chain_l2;
   logic                 chain_l3;
   logic                 chain_link;
   logic                 cnt_clr_n;

   // chain enable into link domain (three stages, agree on 2nd/3rd)
   always_ff @(negedge sclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         chain_l1   <= 1'b0;
         chain_l2   <= 1'b0;
         chain_l3   <= 1'b0;
         chain_link <= 1'b0;
      end else begin
         chain_l1 <= chain_enable_in;
         chain_l2 <= chain_l1;
         chain_l3 <= chain_l2;
         if (chain_l2 == chain_l3) chain_link <= chain_l2;
      end
   end

   // last bit of a word: the position wraps here
   function automatic logic word_end(input logic [CNT_BITS-1:0] pos);
      word_end = (pos == CNT_FULL - 5'h01);
   endfunction

   // cleared while frame sync is high or in reset
   assign cnt_clr_n = rstn_in && !sync_n_in;

   // bit position in the word; wraps so chained words line up
   always_ff @(negedge sclk_in or negedge cnt_clr_n) begin
      if (!cnt_clr_n) begin
         bit_cnt <= CNT_RESET;
      end else if (word_end(bit_cnt)) begin
         bit_cnt <= CNT_RESET;
      end else begin
         bit_cnt <= bit_cnt + 5'h01;
      end
   end

   always_ff @(negedge sclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         shreg <= WORD_RESET;
      end else if (!sync_n_in) begin
         shreg <= {shreg[WORD_BITS-2:0], sdata_in};
      end
   end

   // every 16th edge: hand the word over by toggle
   always_ff @(negedge sclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         auto_tog  <= 1'b0;
         auto_word <= WORD_RESET;
      end else if (!sync_n_in && word_end(bit_cnt)) begin
         auto_tog  <= ~auto_tog;
         auto_word <= {shreg[WORD_BITS-2:0], sdata_in};
      end
   end

   // mirrors the new msb, so the chain sees no extra stage
   always_ff @(negedge sclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         sdata_out <= 1'b0;
      end else if (!chain_link) begin
         sdata_out <= 1'b0;
      end else if (!sync_n_in) begin
         sdata_out <= shreg[WORD_BITS-2];
      end
   end

   // ******************************************
   // system domain: synchronisers
   // ******************************************
   logic [SYNC_STAGES-1:0] tog_sy;
   logic [SYNC_STAGES-1:0] sync_sy;
   logic [SYNC_STAGES-1:0] load_sy;
   logic [SYNC_STAGES-1:0] chain_sy;
   logic                   tog_seen;
   logic                   sync_level;
   logic                   load_level;
   logic                   chain_level;
   logic                   sync_prev;
   logic                   load_prev;

   // new level once stages two and three agree, else the old one
   function automatic logic settle(input logic [SYNC_STAGES-1:0] sy,
                                   input logic                   held);
      settle = (sy[1] == sy[2]) ? sy[2] : held;
   endfunction

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         tog_sy <= '0;
      end else begin
         tog_sy <= {tog_sy[SYNC_STAGES-2:0], auto_tog};
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         sync_sy <= '1;
      end else begin
         sync_sy <= {sync_sy[SYNC_STAGES-2:0], sync_n_in};
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         load_sy <= '1;
      end else begin
         load_sy <= {load_sy[SYNC_STAGES-2:0], load_output_strobe_n_in};
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         chain_sy <= '0;
      end else begin
         chain_sy <= {chain_sy[SYNC_STAGES-2:0], chain_enable_in};
      end
   end

   // a change counts once stages two and three agree
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         tog_seen <= 1'b0;
      end else begin
         tog_seen <= settle(tog_sy, tog_seen);
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         sync_level <= 1'b1;
      end else begin
         sync_level <= settle(sync_sy, sync_level);
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         load_level <= 1'b1;
      end else begin
         load_level <= settle(load_sy, load_level);
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         chain_level <= 1'b0;
      end else begin
         chain_level <= settle(chain_sy, chain_level);
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         sync_prev <= 1'b1;
         load_prev <= 1'b1;
      end else begin
         sync_prev <= sync_level;
         load_prev <= load_level;
      end
   end

   // ******************************************
   // word capture and buffering
   // ******************************************
   logic      tog_prev;
   logic      word_evt;
   dsl_word_s in_word;
   dsl_word_s head;
   logic      buf_ready;
   logic      buf_valid;
   logic      pend_valid;
   dsl_word_s pend_word;

   assign word_evt = (tog_seen != tog_prev);

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         tog_prev <= 1'b0;
      end else if (!pend_valid || buf_ready) begin
         tog_prev <= tog_seen;
      end
   end

   // auto_word is stable well past the toggle, read after sync
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pend_valid <= 1'b0;
         pend_word  <= '0;
      end else if (word_evt && (!pend_valid || buf_ready)) begin
         pend_valid     <= 1'b1;
         pend_word.data <= auto_word;
         pend_word.chained <= chain_level;
      end else if (buf_ready) begin
         pend_valid <= 1'b0;
      end
   end

   assign in_word = pend_word;

   dsl_buf2 #(
      .WIDTH (WORD_BITS + 1)
   ) u_buf (
      .clk_in        (clk_in),
      .rstn_in       (rstn_in),
      .in_valid_in   (pend_valid),
      .in_ready_out  (buf_ready),
      .in_data_in    (in_word),
      .out_valid_out (buf_valid),
      .out_ready_in  (word_ready_in),
      .out_data_out  (head)
   );

   assign word_valid_out = buf_valid;

   // ******************************************
   // output latch update
   // ******************************************
   logic [WORD_BITS-1:0] last_word;
   logic                 have_word;
   logic                 strobe_fall;
   logic                 sync_rise;
   logic                 do_update;

   assign strobe_fall = load_prev && !load_level;
   assign sync_rise   = !sync_prev && sync_level;

   // latest received word, held for a strobe
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         last_word <= WORD_RESET;
         have_word <= 1'b0;
      end else if (word_evt && (!pend_valid || buf_ready)) begin
         last_word <= auto_word;
         have_word <= 1'b1;
      end else if (do_update) begin
         have_word <= 1'b0;
      end
   end

   // strobe falling after the frame, or strobe held low at word end with chaining off
   always_comb begin
      do_update = 1'b0;
      if (strobe_fall && sync_level && have_word) begin
         do_update = 1'b1;
      end else if (!load_level && !chain_level && have_word) begin
         do_update = 1'b1;
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         dac_word_out <= WORD_RESET;
         update_out   <= 1'b0;
      end else begin
         update_out <= do_update;
         if (do_update) dac_word_out <= last_word;
      end
   end

   logic unused_ok;
   assign unused_ok = sync_rise ^ head.chained ^ (|head.data);
endmodule
`default_nettype wire

// >>> dsl_serial_load_assertions.sv
// checker: timing properties of the serial load block
`timescale 1ns/1ps
`default_nettype none
module dsl_serial_load_chk
   import dsl_pkg::*;
(
   input wire logic                 clk_in,          // clock
   input wire logic                 rstn_in,         // reset
   input wire logic                 sclk_in,         // link clock
   input wire logic                 sdata_in,        // link data
   input wire logic                 sync_n_in,       // frame sync
   input wire logic                 load_output_strobe_n_in, // load
   input wire logic                 chain_enable_in, // chain on
   input wire logic                 sdata_out,       // chain out
   input wire logic [WORD_BITS-1:0] dac_word_out,    // latch
   input wire logic                 update_out,      // update
   input wire logic                 word_valid_out,  // pending
   input wire logic                 word_ready_in    // taken
);
   // ***********
   // properties
   // ***********
   sequence strobe_idle;
      (chain_enable_in && load_output_strobe_n_in) [*8];
   endsequence
   chk_update_once: assert property (
      @(posedge clk_in) disable iff (!rstn_in) update_out |=> !update_out)
      else $error("update pulse too long");
   chk_latch_moves: assert property (
      @(posedge clk_in) disable iff (!rstn_in)
      $changed(dac_word_out) |-> update_out)
      else $error("latch changed without update");
   chk_strobe_gate: assert property (
      @(posedge clk_in) disable iff (!rstn_in) update_out && chain_enable_in
      |-> sync_n_in && !load_output_strobe_n_in)
      else $error("chained update without strobe");
   chk_strobe_idle: assert property (
      @(posedge clk_in) disable iff (!rstn_in) strobe_idle |-> !update_out)
      else $error("update with strobe high");
   chk_reset_quiet: assert property (
      @(posedge clk_in) disable iff (!rstn_in) $rose(rstn_in)
      |-> dac_word_out == 16'h0000 && !update_out && !word_valid_out)
      else $error("outputs not cleared by reset");
   chk_buf_holds: assert property (
      @(posedge clk_in) disable iff (!rstn_in)
      word_valid_out && !word_ready_in |=> word_valid_out)
      else $error("buffered word lost");
   chk_chain_off: assert property (
      @(negedge sclk_in) disable iff (!rstn_in)
      !chain_enable_in [*5] |=> !sdata_out)
      else $error("serial out active with chaining off");
   chk_sync_ignore: assert property (
      @(negedge sclk_in) disable iff (!rstn_in) sync_n_in && chain_enable_in
      |=> sdata_out == $past(sdata_out))
      else $error("shift while frame sync high");
endmodule
bind dsl_serial_load dsl_serial_load_chk u_chk (
   .clk_in(clk_in), .rstn_in(rstn_in), .sclk_in(sclk_in),
   .sdata_in(sdata_in), .sync_n_in(sync_n_in),
   .load_output_strobe_n_in(load_output_strobe_n_in),
   .chain_enable_in(chain_enable_in), .sdata_out(sdata_out),
   .dac_word_out(dac_word_out), .update_out(update_out),
   .word_valid_out(word_valid_out), .word_ready_in(word_ready_in));
`default_nettype wire

// >>> dsl_host_model.sv
// host serial port model driving the link
`timescale 1ns/1ps
`default_nettype none
module dsl_host_model (
   output logic sclk_out,   // link clock
   output logic sdata_out,  // link data
   output logic sync_n_out, // frame sync
   output logic load_n_out  // load strobe
);
   initial begin
      sclk_out = 1'b1;
      sdata_out = 1'b0;
      sync_n_out = 1'b1;
      load_n_out = 1'b1;
   end
   task automatic frame(input logic [63:0] bits, input int n);
      sync_n_out = 1'b0;
      #30;
      for (int i = n - 1; i >= 0; i--) begin
         sdata_out = bits[i]; // msb first
         #24 sclk_out = 1'b0; // data valid at fall
         #24 sclk_out = 1'b1;
         if (i % 8 == 0 && i > 0) #100; // sync held between bytes
      end
      #60 sync_n_out = 1'b1; // after last byte
      sdata_out = ~sdata_out;
   endtask
   task automatic stray();
      repeat (3) begin
         #24 sclk_out = 1'b0;
         #24 sclk_out = 1'b1;
      end
   endtask
   task automatic strobe();
      #50 load_n_out = 1'b0; // after sync rise
      #120 load_n_out = 1'b1; // width over 100 ns
   endtask
endmodule
`default_nettype wire

// >>> tb_top.sv
// testbench for the serial load block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import dsl_pkg::*;
   logic                 clk_in, rstn_in, chain, ready;
   logic                 sclk, sdi, sync_n, load_n, sdo, upd, valid;
   logic [WORD_BITS-1:0] dac;
   logic [15:0]          cap;
   int                   num_errors, checked;
   initial begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end
   dsl_host_model host (.sclk_out(sclk), .sdata_out(sdi),
      .sync_n_out(sync_n), .load_n_out(load_n));
   dsl_serial_load dut (.clk_in(clk_in), .rstn_in(rstn_in), .sclk_in(sclk),
      .sdata_in(sdi), .sync_n_in(sync_n), .load_output_strobe_n_in(load_n),
      .chain_enable_in(chain), .sdata_out(sdo), .dac_word_out(dac),
      .update_out(upd), .word_valid_out(valid), .word_ready_in(ready));
   always @(negedge sclk) if (!sync_n) cap <= {cap[14:0], sdo};
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic wait_upd();
      int n;
      n = 0;
      while (upd !== 1'b1 && n < 400) begin
         @(negedge clk_in);
         n++;
      end
      if (n >= 400) begin
         num_errors++;
         results();
      end
   endtask
   task automatic t_strobe();
      host.frame(64'hA53C, 16);
      repeat (20) @(negedge clk_in);
      check(dac, 32'h0);
      fork host.strobe(); wait_upd(); join
      check(dac, 32'hA53C);
      $display("test strobe done");
   endtask
   task automatic t_auto();
      host.load_n_out = 1'b0;
      fork host.frame(64'h8001, 16); wait_upd(); join_any
      check(sync_n, 32'h0);
      wait fork;
      @(negedge clk_in);
      check(dac, 32'h8001);
      host.load_n_out = 1'b1;
      $display("test auto done");
   endtask
   task automatic t_buffer();
      check(valid, 32'h1);
      ready = 1'b1;
      repeat (6) @(negedge clk_in);
      check(valid, 32'h0);
      $display("test buffer done");
   endtask
   task automatic t_chain();
      chain = 1'b1;
      host.stray();
      host.frame(64'h1234_CDEF, 32);
      repeat (20) @(negedge clk_in);
      check(dac, 32'h8001);
      fork host.strobe(); wait_upd(); join
      check(dac, 32'hCDEF);
      check(cap, 32'h1234);
      $display("test chain done");
   endtask
   initial begin
      rstn_in = 1'b0;
      chain = 1'b0;
      ready = 1'b0;
      cap = 16'h0000;
      num_errors = 0;
      checked = 0;
      repeat (8) @(negedge clk_in);
      rstn_in = 1'b1;
      @(negedge clk_in);
      check(dac, 32'h0);
      check(valid, 32'h0);
      $display("test reset done");
      t_strobe();
      t_auto();
      t_buffer();
      t_chain();
      results();
   end
endmodule
`default_nettype wire
